// ### inc/rlqm_map.svh
// Register offsets, field positions, reset values and sizes of the link quality monitor.
// Assumes inclusion from the package and from design files by bare name.
`ifndef RLQM_MAP_SVH
`define RLQM_MAP_SVH

`define RLQM_OFS_STATUS 8'h03
`define RLQM_OFS_QUALITY 8'h04
`define RLQM_OFS_LOSS 8'h05
`define RLQM_OFS_MODE 8'h30
`define RLQM_OFS_WARN_TH 8'h31
`define RLQM_OFS_ERR_TH 8'h32

`define RLQM_RST_STATUS 8'h00
`define RLQM_RST_QUALITY 8'h00
`define RLQM_RST_LOSS 8'h00
`define RLQM_RST_MODE 8'h00
`define RLQM_RST_WARN_TH 8'hff
`define RLQM_RST_ERR_TH 8'hff

`define RLQM_STA_LOSS_CHG 5
`define RLQM_STA_QUAL_CHG 4
`define RLQM_STA_LINK_UP 0

`define RLQM_MODE_RESTORE 6
`define RLQM_MODE_LOSS_ACT_HI 3
`define RLQM_MODE_LOSS_ACT_LO 2
`define RLQM_MODE_QUAL_ACT_HI 1
`define RLQM_MODE_QUAL_ACT_LO 0
// Bits of the mode register that hold state; the rest read as zero
`define RLQM_MODE_KEEP_MASK 8'h4f

`define RLQM_HIST_DEPTH 256
`define RLQM_HIST_AW 8
`define RLQM_COUNT_MAX 8'hff

`endif

// ### inc/rlqm_pkg.sv
// Types shared by the link quality monitor files.
// Assumes rlqm_map.svh is on the include path.
`default_nettype none
`include "rlqm_map.svh"
package rlqm_pkg;
  typedef logic [7:0] rlqm_byte_t;
  typedef logic [`RLQM_HIST_AW-1:0] rlqm_hptr_t;
  // Response to a threshold condition; 01 and 10 are reserved
  typedef enum logic [1:0] {
    RLQM_ACT_MUTE = 2'b00,
    RLQM_ACT_NONE = 2'b11
  } rlqm_act_t;
endpackage : rlqm_pkg
`default_nettype wire

// ### design/rlqm_hist_mem.sv
// One-bit-wide history memory of recent packet outcomes.
// Assumes one access per cycle; read data is the old content, registered.
`default_nettype none
module rlqm_hist_mem
  import rlqm_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic we, // Write strobe
  input wire rlqm_hptr_t addr, // Entry address
  input wire logic wdata, // New outcome bit
  output logic rdata // Outcome previously stored at addr
);
  logic mem [0:`RLQM_HIST_DEPTH-1];
  logic rdata_reg;

  // Memory array has no reset; the valid mask in the parent hides stale entries
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= 1'b0;
    end else begin
      rdata_reg <= mem[addr];
    end
  end

  assign rdata = rdata_reg;
endmodule : rlqm_hist_mem
`default_nettype wire

// ### design/rlqm_top.sv
// Link quality monitor: packet quality window, loss count cleared each loss period,
// threshold interrupt, link status flags and mute response.
// Assumes all inputs synchronous to clk and register accesses as single-cycle strobes.
`default_nettype none
`include "rlqm_map.svh"
module rlqm_top
  import rlqm_pkg::*;
(
  input wire logic clk, // 40 MHz system clock
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  input wire rlqm_byte_t reg_addr, // Register offset
  input wire rlqm_byte_t reg_wdata, // Register write data
  output rlqm_byte_t reg_rdata, // Register read data, one cycle after reg_rd
  input wire logic pkt_done, // Pulse: one packet transfer finished
  input wire logic pkt_ok, // Outcome of that packet, 1 = success
  input wire logic audio_due, // Pulse: audio output needs a packet now
  input wire logic audio_ready, // The needed packet was received in time
  input wire logic loss_period_tick, // Pulse: start of a new loss counting period
  input wire logic link_up, // Level: link established
  input wire logic link_init_done, // Pulse: a link initialization finished
  input wire logic counterpart_found, // Counterpart seen during that initialization
  input wire logic link_irq_enable, // Link interrupt enable from interrupt_config
  input wire logic [15:0] audio_in, // Audio sample before the mute stage
  output logic [15:0] audio_out, // Audio sample after the mute stage
  output logic irq, // Interrupt request, active high level
  output logic audio_mute, // Level: mute currently forced
  output logic restore_defaults // Pulse: both sides return to initial contents
);
  function automatic logic act_is_mute(input logic [1:0] act);
    act_is_mute = (act == RLQM_ACT_MUTE);
  endfunction : act_is_mute

  rlqm_byte_t mode_reg, mode_next;
  rlqm_byte_t warn_th_reg, warn_th_next;
  rlqm_byte_t err_th_reg, err_th_next;
  rlqm_byte_t loss_reg, loss_next;
  logic [8:0] good_reg, good_next;
  rlqm_hptr_t ptr_reg;
  logic [`RLQM_HIST_DEPTH-1:0] valid_reg;
  logic upd_reg;
  logic new_bit_reg;
  logic old_valid_reg;
  logic qual_chg_reg, qual_chg_next;
  logic loss_chg_reg, loss_chg_next;
  logic [15:0] audio_out_reg;
  rlqm_byte_t rdata_reg, rdata_next;
  logic restore_reg;
  logic old_bit;

  // Decoded strobes
  wire logic wr_mode = reg_wr && (reg_addr == `RLQM_OFS_MODE);
  wire logic wr_warn = reg_wr && (reg_addr == `RLQM_OFS_WARN_TH);
  wire logic wr_err = reg_wr && (reg_addr == `RLQM_OFS_ERR_TH);
  wire logic rd_status = reg_rd && (reg_addr == `RLQM_OFS_STATUS);

  wire logic restore_hit = link_init_done && !counterpart_found
                           && mode_reg[`RLQM_MODE_RESTORE];

  rlqm_hist_mem u_hist (
    .clk(clk),
    .sys_rst(sys_rst),
    .we(pkt_done),
    .addr(ptr_reg),
    .wdata(pkt_ok),
    .rdata(old_bit)
  );

  // The raw sum can reach 256; the register reports at most 255
  wire logic old_good = old_bit && old_valid_reg;
  wire logic [8:0] good_sum = good_reg + {8'h00, new_bit_reg} - {8'h00, old_good};
  wire rlqm_byte_t quality = (good_reg[8]) ? `RLQM_COUNT_MAX : good_reg[7:0];

  wire logic lost_now = audio_due && !audio_ready;
  wire logic loss_sat = (loss_reg == `RLQM_COUNT_MAX);

  always_comb begin
    good_next = good_reg;
    if (upd_reg) begin
      good_next = good_sum;
    end
  end

  always_comb begin
    loss_next = loss_reg;
    if (loss_period_tick) begin
      // A loss in the tick cycle opens the new period at one
      loss_next = lost_now ? 8'h01 : 8'h00;
    end else if (lost_now && !loss_sat) begin
      loss_next = loss_reg + 8'h01;
    end
  end

  // Sticky change flags, cleared by a status read; a change wins
  wire logic qual_changed = upd_reg && (good_sum != good_reg);
  wire logic loss_changed = (loss_next != loss_reg);

  always_comb begin
    qual_chg_next = qual_chg_reg;
    loss_chg_next = loss_chg_reg;
    if (rd_status) begin
      qual_chg_next = 1'b0;
      loss_chg_next = 1'b0;
    end
    if (qual_changed) begin
      qual_chg_next = 1'b1;
    end
    if (loss_changed) begin
      loss_chg_next = 1'b1;
    end
  end

  // Reserved mode bits are dropped so they never act or read back
  always_comb begin
    mode_next = mode_reg;
    warn_th_next = warn_th_reg;
    err_th_next = err_th_reg;
    if (restore_hit) begin
      mode_next = `RLQM_RST_MODE;
      warn_th_next = `RLQM_RST_WARN_TH;
      err_th_next = `RLQM_RST_ERR_TH;
    end else begin
      if (wr_mode) begin
        mode_next = reg_wdata & `RLQM_MODE_KEEP_MASK;
      end
      if (wr_warn) begin
        warn_th_next = reg_wdata;
      end
      if (wr_err) begin
        err_th_next = reg_wdata;
      end
    end
  end

  wire rlqm_byte_t status_val = {2'b00, loss_chg_reg, qual_chg_reg, 3'b000, link_up};

  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `RLQM_OFS_STATUS: rdata_next = status_val;
        `RLQM_OFS_QUALITY: rdata_next = quality;
        `RLQM_OFS_LOSS: rdata_next = loss_reg;
        `RLQM_OFS_MODE: rdata_next = mode_reg;
        `RLQM_OFS_WARN_TH: rdata_next = warn_th_reg;
        `RLQM_OFS_ERR_TH: rdata_next = err_th_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  wire logic warn_irq = (quality <= warn_th_reg);
  wire logic err_irq = (loss_reg >= err_th_reg);

  // Loss response selects mute only for 00; reserved codes act as no action
  wire logic loss_mute = act_is_mute(mode_reg[`RLQM_MODE_LOSS_ACT_HI:`RLQM_MODE_LOSS_ACT_LO])
                         && (loss_reg > err_th_reg);
  wire logic qual_mute = act_is_mute(mode_reg[`RLQM_MODE_QUAL_ACT_HI:`RLQM_MODE_QUAL_ACT_LO])
                         && (quality < warn_th_reg);
  wire logic mute_now = loss_mute || qual_mute;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_reg <= '0;
      valid_reg <= '0;
      upd_reg <= 1'b0;
      new_bit_reg <= 1'b0;
      old_valid_reg <= 1'b0;
    end else begin
      upd_reg <= pkt_done;
      new_bit_reg <= pkt_ok;
      old_valid_reg <= valid_reg[ptr_reg];
      if (pkt_done) begin
        ptr_reg <= ptr_reg + 1'b1;
        valid_reg[ptr_reg] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      good_reg <= 9'h000;
      loss_reg <= `RLQM_RST_LOSS;
      qual_chg_reg <= 1'b0;
      loss_chg_reg <= 1'b0;
    end else begin
      good_reg <= good_next;
      loss_reg <= loss_next;
      qual_chg_reg <= qual_chg_next;
      loss_chg_reg <= loss_chg_next;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_reg <= `RLQM_RST_MODE;
      warn_th_reg <= `RLQM_RST_WARN_TH;
      err_th_reg <= `RLQM_RST_ERR_TH;
      rdata_reg <= 8'h00;
      restore_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      warn_th_reg <= warn_th_next;
      err_th_reg <= err_th_next;
      rdata_reg <= rdata_next;
      restore_reg <= restore_hit;
    end
  end

  // Silence while the mute condition holds
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      audio_out_reg <= 16'h0000;
    end else begin
      audio_out_reg <= mute_now ? 16'h0000 : audio_in;
    end
  end

  assign irq = link_irq_enable && (warn_irq || err_irq);
  assign audio_mute = mute_now;
  assign audio_out = audio_out_reg;
  assign reg_rdata = rdata_reg;
  assign restore_defaults = restore_reg;
endmodule : rlqm_top
`default_nettype wire

// ### bench/rlqm_top_asserts.sv
// Port-level checks of the link quality monitor.
// Assumes it is bound onto rlqm_top and sees only its ports.
`default_nettype none
module rlqm_top_asserts
  import rlqm_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic sys_rst, // Reset, active high
  input wire logic reg_rd, // Read strobe
  input wire rlqm_byte_t reg_addr, // Offset
  input wire rlqm_byte_t reg_rdata, // Read data
  input wire logic link_up, // Link level
  input wire logic link_init_done, // Init finished
  input wire logic counterpart_found, // Counterpart seen
  input wire logic link_irq_enable, // Interrupt enable
  input wire logic [15:0] audio_in, // Sample in
  input wire logic [15:0] audio_out, // Sample out
  input wire logic irq, // Interrupt request
  input wire logic audio_mute, // Mute level
  input wire logic restore_defaults // Restore pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_sta_rd;
    reg_rd && reg_addr == 8'h03;
  endsequence
  sequence s_mode_rd;
    reg_rd && reg_addr == 8'h30;
  endsequence
  AST_STA_FMT: assert property (s_sta_rd |=> reg_rdata[7:6] == 2'b00
    && reg_rdata[3:1] == 3'b000 && reg_rdata[0] == $past(link_up))
    else $error("status layout wrong");
  AST_MODE_RSVD: assert property (s_mode_rd |=> reg_rdata[7] == 1'b0 && reg_rdata[5:4] == 2'b00)
    else $error("mode reserved bits not zero");
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data not idle");
  AST_IRQ_EN: assert property (!link_irq_enable |-> !irq) else $error("irq while disabled");
  AST_MUTE: assert property (audio_mute |=> audio_out == 16'h0000) else $error("mute leaks");
  AST_PASS: assert property (!audio_mute |=> audio_out == $past(audio_in))
    else $error("audio not passed");
  AST_RESTORE: assert property (restore_defaults |-> $past(link_init_done && !counterpart_found))
    else $error("restore without failed init");
  AST_PULSE: assert property (restore_defaults |=> !restore_defaults)
    else $error("restore pulse too long");
endmodule : rlqm_top_asserts
bind rlqm_top rlqm_top_asserts u_chk (.clk, .sys_rst, .reg_rd, .reg_addr, .reg_rdata, .link_up,
  .link_init_done, .counterpart_found, .link_irq_enable, .audio_in, .audio_out, .irq,
  .audio_mute, .restore_defaults);
`default_nettype wire

// ### bench/rlqm_host.sv
// Host model driving the register strobe port.
// Assumes read data answers in the cycle after the read strobe.
`default_nettype none
module rlqm_host
  import rlqm_pkg::*;
(
  input wire logic clk, // System clock
  output logic reg_wr, // Write strobe
  output logic reg_rd, // Read strobe
  output rlqm_byte_t reg_addr, // Offset
  output rlqm_byte_t reg_wdata, // Write data
  input wire rlqm_byte_t reg_rdata // Read data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input rlqm_byte_t a, input rlqm_byte_t v);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~v;
  endtask : wr
  task automatic rd(input rlqm_byte_t a, output rlqm_byte_t v);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    v = reg_rdata;
  endtask : rd
endmodule : rlqm_host
`default_nettype wire

// ### bench/rlqm_top_tb_top.sv
// Self-checking bench of the link quality monitor.
// Assumes the host model owns the register port; all else is driven here.
`default_nettype none
module rlqm_top_tb_top
  import rlqm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {rlqm_byte_t a; rlqm_byte_t e;} rlqm_row_t;
  logic clk, sys_rst, reg_wr, reg_rd, pkt_done, pkt_ok, audio_due, audio_ready;
  logic loss_period_tick, link_up, link_init_done, counterpart_found, link_irq_enable;
  logic irq, audio_mute, restore_defaults;
  rlqm_byte_t reg_addr, reg_wdata, reg_rdata, d;
  logic [15:0] audio_in, audio_out;
  int failures, checked;
  rlqm_row_t rows[7] = '{'{8'h03, 8'h00}, '{8'h04, 8'h00}, '{8'h05, 8'h00}, '{8'h30, 8'h00},
    '{8'h31, 8'hff}, '{8'h32, 8'hff}, '{8'h10, 8'h00}};
  rlqm_top dut (.clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .pkt_done,
    .pkt_ok, .audio_due, .audio_ready, .loss_period_tick, .link_up, .link_init_done,
    .counterpart_found, .link_irq_enable, .audio_in, .audio_out, .irq, .audio_mute,
    .restore_defaults);
  rlqm_host host (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rdchk(input rlqm_byte_t a, input rlqm_byte_t e);
    host.rd(a, d);
    chk($sformatf("reg %h", a), {8'h00, d}, {8'h00, e});
  endtask : rdchk
  task automatic pkt(input logic ok);
    @(negedge clk);
    pkt_done = 1'b1;
    pkt_ok = ok;
    @(negedge clk);
    pkt_done = 1'b0;
    pkt_ok = ~ok;
  endtask : pkt
  task automatic due(input logic rdy);
    @(negedge clk);
    audio_due = 1'b1;
    audio_ready = rdy;
    @(negedge clk);
    audio_due = 1'b0;
  endtask : due
  task automatic init(input logic f);
    @(negedge clk);
    link_init_done = 1'b1;
    counterpart_found = f;
    @(negedge clk);
    link_init_done = 1'b0;
    counterpart_found = 1'b1;
    chk("restore", {15'h0, restore_defaults}, {15'h0, !f});
  endtask : init
  task automatic end_of_test();
    if (failures == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  initial begin
    sys_rst = 1'b1;
    {pkt_done, pkt_ok, audio_due, audio_ready, loss_period_tick} = 5'h00;
    {link_up, link_init_done, counterpart_found, link_irq_enable} = 4'h2;
    audio_in = 16'h1234;
    failures = 0;
    checked = 0;
    repeat (8) @(posedge clk);
    @(negedge clk) sys_rst = 1'b0;
    foreach (rows[i]) rdchk(rows[i].a, rows[i].e);
    chk("mute", {15'h0, audio_mute}, 16'h1);
    chk("irq", {15'h0, irq}, 16'h0);
    @(negedge clk) link_irq_enable = 1'b1;
    // Let the combinational request settle before looking at it
    @(negedge clk);
    chk("irq", {15'h0, irq}, 16'h1);
    pkt(1'b1);
    pkt(1'b1);
    pkt(1'b1);
    pkt(1'b0);
    repeat (2) @(negedge clk);
    rdchk(8'h04, 8'h03);
    rdchk(8'h03, 8'h10);
    @(negedge clk) link_up = 1'b1;
    rdchk(8'h03, 8'h01);
    due(1'b0);
    due(1'b1);
    due(1'b0);
    rdchk(8'h05, 8'h02);
    rdchk(8'h03, 8'h21);
    host.wr(8'h31, 8'h02);
    host.wr(8'h32, 8'h03);
    chk("irq", {15'h0, irq}, 16'h0);
    chk("mute", {15'h0, audio_mute}, 16'h0);
    @(negedge clk);
    chk("audio", audio_out, 16'h1234);
    host.wr(8'h32, 8'h02);
    chk("irq", {15'h0, irq}, 16'h1);
    chk("mute", {15'h0, audio_mute}, 16'h0);
    host.wr(8'h32, 8'h01);
    chk("mute", {15'h0, audio_mute}, 16'h1);
    @(negedge clk);
    chk("audio", audio_out, 16'h0000);
    host.wr(8'h30, 8'h0c);
    chk("mute", {15'h0, audio_mute}, 16'h0);
    host.wr(8'h32, 8'hff);
    host.wr(8'h31, 8'h03);
    chk("irq", {15'h0, irq}, 16'h1);
    chk("mute", {15'h0, audio_mute}, 16'h0);
    host.wr(8'h31, 8'h04);
    chk("mute", {15'h0, audio_mute}, 16'h1);
    host.wr(8'h30, 8'hff);
    rdchk(8'h30, 8'h4f);
    chk("mute", {15'h0, audio_mute}, 16'h0);
    host.wr(8'h04, 8'h55);
    rdchk(8'h04, 8'h03);
    @(negedge clk) loss_period_tick = 1'b1;
    @(negedge clk) loss_period_tick = 1'b0;
    rdchk(8'h05, 8'h00);
    // A loss in the same cycle as the status read must leave its flag set
    fork
      host.rd(8'h03, d);
      due(1'b0);
    join
    chk("status", {8'h00, d}, 16'h0021);
    rdchk(8'h03, 8'h21);
    rdchk(8'h03, 8'h01);
    init(1'b1);
    rdchk(8'h30, 8'h4f);
    init(1'b0);
    rdchk(8'h30, 8'h00);
    rdchk(8'h31, 8'hff);
    // Reset in mid-run clears the packet window
    @(negedge clk) sys_rst = 1'b1;
    @(negedge clk) sys_rst = 1'b0;
    rdchk(8'h04, 8'h00);
    rdchk(8'h03, 8'h01);
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    end_of_test();
  end
endmodule : rlqm_top_tb_top
`default_nettype wire
